// ---- encoder_emulation_params.svh ----
// Constants for the incremental encoder emulation.
`ifndef ENCODER_EMULATION_PARAMS_SVH
`define ENCODER_EMULATION_PARAMS_SVH

// ----------------------------------------------------------------------------
// Clock and output rate
// ----------------------------------------------------------------------------
`define EMU_CLK_FREQ_KHZ 25000
`define EMU_MAX_TRACK_FREQ_KHZ 256
`define EMU_EDGES_PER_PULSE 4
`define EMU_MIN_EDGE_CYCLES \
    ((`EMU_CLK_FREQ_KHZ + `EMU_MAX_TRACK_FREQ_KHZ * `EMU_EDGES_PER_PULSE - 1) / \
     (`EMU_MAX_TRACK_FREQ_KHZ * `EMU_EDGES_PER_PULSE))

// ----------------------------------------------------------------------------
// Source selector and word layouts
// ----------------------------------------------------------------------------
`define EMU_SRC_SPEED 1'b0
`define EMU_SRC_POSITION 1'b1
`define EMU_SPEED_FRAC_BITS 24
`define EMU_COMP_FRAC_BITS 8
`define EMU_DELAY_DEPTH 16
`define EMU_CTRL_ON_BIT 0
`define EMU_CTRL_RAMP_STOP_BIT 1
`define EMU_STAT_READY_BIT 0
`define EMU_STAT_RUNNING_BIT 1
`define EMU_STAT_TRACKS_BIT 2
`define EMU_STAT_FAULT_BIT 3

// ----------------------------------------------------------------------------
// Operating display codes and reset values
// ----------------------------------------------------------------------------
`define EMU_DISP_OFF 8'h00
`define EMU_DISP_RUN 8'h01
`define EMU_DISP_STOPPING 8'h02
`define EMU_DISP_POSITION 8'h03
`define EMU_DISP_FAULT 8'hff
`define EMU_RESET_COUNT 32'h0000_0000
`define EMU_RESET_ACCUM 56'h00_0000_0000_0000

`endif

// ---- encoder_emulation_pkg.sv ----
// Types shared by the incremental encoder emulation modules.
`default_nettype none

package encoder_emulation_pkg;

    // ------------------------------------------------------------------------
    // Sequence control states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_RUN,
        SEQ_STOPPING
    } seq_state_type;

endpackage

`default_nettype wire

// ---- speed_shaper.sv ----
// Second-order lag filter and deadtime delay for the speed setpoint.
`default_nettype none
`include "encoder_emulation_params.svh"

module speed_shaper (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sample_i,
    input wire logic filter_enable_i,
    input wire logic [3:0] time_constant_i,
    input wire logic [3:0] damping_i,
    input wire logic [3:0] deadtime_i,
    input wire logic signed [31:0] speed_i,
    output logic signed [31:0] speed_o
);

    logic signed [31:0] lag1_q, lag1_d, lag2_q, lag2_d;
    logic signed [31:0] delay_q [`EMU_DELAY_DEPTH];
    logic signed [31:0] delay_d [`EMU_DELAY_DEPTH];

    // A positive remainder below one shifted step still moves one count.
    // The lag therefore settles exactly on its input.
    function automatic logic signed [31:0] lag_step(input logic signed [31:0] diff,
        input logic [3:0] shift);
        lag_step = diff >>> shift;
        if (lag_step == 32'sd0 && diff > 32'sd0) begin
            lag_step = 32'sd1;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Filter and delay line
    // ------------------------------------------------------------------------
    always_comb begin
        lag1_d = lag1_q;
        lag2_d = lag2_q;
        for (int i = 0; i < `EMU_DELAY_DEPTH; i++) begin
            delay_d[i] = delay_q[i];
        end
        if (sample_i) begin
            if (filter_enable_i) begin
                lag1_d = lag1_q + lag_step(speed_i - lag1_q, time_constant_i);
                lag2_d = lag2_q + lag_step(lag1_q - lag2_q, damping_i);
            end else begin
                lag1_d = speed_i;
                lag2_d = speed_i;
            end
            delay_d[0] = lag2_d;
            for (int i = 1; i < `EMU_DELAY_DEPTH; i++) begin
                delay_d[i] = delay_q[i-1];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lag1_q <= '0;
            lag2_q <= '0;
            for (int i = 0; i < `EMU_DELAY_DEPTH; i++) begin
                delay_q[i] <= '0;
            end
        end else begin
            lag1_q <= lag1_d;
            lag2_q <= lag2_d;
            for (int i = 0; i < `EMU_DELAY_DEPTH; i++) begin
                delay_q[i] <= delay_d[i];
            end
        end
    end

    assign speed_o = (deadtime_i == 4'h0) ? lag2_q : delay_q[deadtime_i - 4'h1];

endmodule // speed_shaper

`default_nettype wire

// ---- quad_track_gen.sv ----
// Rate-limited quadrature track generator that follows a target edge count.
`default_nettype none
`include "encoder_emulation_params.svh"

module quad_track_gen (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic signed [31:0] target_i,
    output logic signed [31:0] count_o,
    output logic step_o,
    output logic dir_up_o,
    output logic track_a_o,
    output logic track_b_o
);

    localparam int unsigned GAP = `EMU_MIN_EDGE_CYCLES;

    logic signed [31:0] count_q, count_d;
    logic [7:0] gap_q, gap_d;
    logic a_q, a_d, b_q, b_d;
    logic want_up, want_down;

    // ------------------------------------------------------------------------
    // Edge stepping
    // ------------------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        gap_d = (gap_q != 8'h00) ? gap_q - 8'h01 : 8'h00;
        a_d = a_q;
        b_d = b_q;
        want_up = enable_i && (target_i > count_q);
        want_down = enable_i && (target_i < count_q);
        step_o = (want_up || want_down) && (gap_q == 8'h00);
        dir_up_o = want_up;
        if (step_o) begin
            gap_d = 8'(GAP - 1);
            if (want_up) begin
                count_d = count_q + 32'sd1;
                if (a_q == b_q) a_d = ~a_q;
                else b_d = ~b_q;
            end else begin
                count_d = count_q - 32'sd1;
                if (a_q == b_q) b_d = ~b_q;
                else a_d = ~a_q;
            end
        end
        if (!enable_i) begin
            count_d = target_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= `EMU_RESET_COUNT;
            gap_q <= 8'h00;
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            count_q <= count_d;
            gap_q <= gap_d;
            a_q <= a_d;
            b_q <= b_d;
        end
    end

    assign count_o = count_q;
    assign track_a_o = a_q;
    assign track_b_o = b_q;

endmodule // quad_track_gen

`default_nettype wire

// ---- encoder_emulation.sv ----
// Incremental encoder emulation: speed or position source to A/B/zero tracks.
`default_nettype none
`include "encoder_emulation_params.svh"

module encoder_emulation (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic emulation_source_select_i,
    input wire logic [15:0] pulses_per_revolution_i,
    input wire logic zero_mark_enable_i,
    input wire logic [15:0] zero_mark_pulse_distance_i,
    input wire logic position_input_invert_i,
    input wire logic [7:0] deadtime_compensation_i,
    input wire logic [4:0] fine_resolution_bits_i,
    input wire logic [15:0] emulation_sample_period_i,
    input wire logic signed [31:0] source_encoder_position_i,
    input wire logic source_is_resolver_i,
    input wire logic source_is_absolute_i,
    input wire logic position_enable_i,
    input wire logic on_ramp_stop_command_command_i,
    input wire logic setpoint_filter_enable_i,
    input wire logic [3:0] filter_time_constant_i,
    input wire logic [3:0] filter_damping_i,
    input wire logic [3:0] setpoint_deadtime_i,
    input wire logic signed [31:0] speed_setpoint_input_i,
    output logic track_a_p_o,
    output logic track_a_n_o,
    output logic track_b_p_o,
    output logic track_b_n_o,
    output logic track_z_p_o,
    output logic track_z_n_o,
    output logic tracks_enabled_flag_o,
    output logic unsupported_source_o,
    output logic [15:0] sequence_control_word_o,
    output logic [15:0] sequence_status_word_o,
    output logic [7:0] operating_display_o
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [17:0] edges_of(input logic [15:0] pulses);
        edges_of = {pulses, 2'b00};
    endfunction

    // ------------------------------------------------------------------------
    // Sample tick
    // ------------------------------------------------------------------------
    logic [15:0] tick_cnt_q, tick_cnt_d;
    logic sample;

    always_comb begin
        sample = (tick_cnt_q + 16'h0001 >= emulation_sample_period_i);
        tick_cnt_d = sample ? 16'h0000 : tick_cnt_q + 16'h0001;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // ------------------------------------------------------------------------
    // Sequence control for the speed source
    // ------------------------------------------------------------------------
    encoder_emulation_pkg::seq_state_type seq_q, seq_d;
    logic speed_mode, pos_mode, fault, tracks_on;
    logic signed [31:0] shaped_speed;
    logic signed [31:0] gen_count;
    logic signed [31:0] target;
    logic gen_step, gen_up, gen_a, gen_b;

    assign speed_mode = (emulation_source_select_i == `EMU_SRC_SPEED);
    assign pos_mode = (emulation_source_select_i == `EMU_SRC_POSITION);
    assign fault = pos_mode && source_is_resolver_i;

    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            encoder_emulation_pkg::SEQ_OFF: begin
                if (speed_mode && on_ramp_stop_command_command_i) begin
                    seq_d = encoder_emulation_pkg::SEQ_RUN;
                end
            end
            encoder_emulation_pkg::SEQ_RUN: begin
                if (!speed_mode) begin
                    seq_d = encoder_emulation_pkg::SEQ_OFF;
                end else if (!on_ramp_stop_command_command_i) begin
                    seq_d = encoder_emulation_pkg::SEQ_STOPPING;
                end
            end
            encoder_emulation_pkg::SEQ_STOPPING: begin
                if (!speed_mode) begin
                    seq_d = encoder_emulation_pkg::SEQ_OFF;
                end else if (on_ramp_stop_command_command_i) begin
                    seq_d = encoder_emulation_pkg::SEQ_RUN;
                end else if (shaped_speed == 32'sd0 && gen_count == target) begin
                    seq_d = encoder_emulation_pkg::SEQ_OFF;
                end
            end
            default: begin
                seq_d = encoder_emulation_pkg::SEQ_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_q <= encoder_emulation_pkg::SEQ_OFF;
        end else begin
            seq_q <= seq_d;
        end
    end

    always_comb begin
        if (speed_mode) begin
            tracks_on = (seq_q != encoder_emulation_pkg::SEQ_OFF);
        end else begin
            tracks_on = position_enable_i && !fault;
        end
    end

    // ------------------------------------------------------------------------
    // Speed path
    // ------------------------------------------------------------------------
    logic signed [31:0] speed_cmd;

    assign speed_cmd = (seq_q == encoder_emulation_pkg::SEQ_RUN) ?
        speed_setpoint_input_i : 32'sd0;

    speed_shaper speed_shaper_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sample_i(sample),
        .filter_enable_i(setpoint_filter_enable_i),
        .time_constant_i(filter_time_constant_i),
        .damping_i(filter_damping_i),
        .deadtime_i(setpoint_deadtime_i),
        .speed_i(speed_cmd),
        .speed_o(shaped_speed)
    );

    logic signed [55:0] accum_q, accum_d;
    logic signed [55:0] speed_inc;

    always_comb begin
        speed_inc = 56'(shaped_speed) *
            56'($signed({14'h0000, edges_of(pulses_per_revolution_i)}));
        accum_d = accum_q;
        if (!speed_mode || !tracks_on) begin
            accum_d = `EMU_RESET_ACCUM;
        end else if (sample) begin
            accum_d = accum_q + speed_inc;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            accum_q <= `EMU_RESET_ACCUM;
        end else begin
            accum_q <= accum_d;
        end
    end

    // ------------------------------------------------------------------------
    // Position path
    // ------------------------------------------------------------------------
    logic signed [31:0] pos_in, pos_prev_q, pos_prev_d, pos_pred_q, pos_pred_d;
    logic signed [40:0] comp_term;
    logic [4:0] shift_amt;

    always_comb begin
        pos_in = position_input_invert_i ? -source_encoder_position_i :
            source_encoder_position_i;
        comp_term = 41'(pos_in - pos_prev_q) * 41'($signed({1'b0, deadtime_compensation_i}));
        shift_amt = (fine_resolution_bits_i > 5'd2) ? fine_resolution_bits_i - 5'd2 : 5'd0;
        pos_prev_d = pos_prev_q;
        pos_pred_d = pos_pred_q;
        if (sample) begin
            pos_prev_d = pos_in;
            pos_pred_d = pos_in + 32'(comp_term >>> `EMU_COMP_FRAC_BITS);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_prev_q <= `EMU_RESET_COUNT;
            pos_pred_q <= `EMU_RESET_COUNT;
        end else begin
            pos_prev_q <= pos_prev_d;
            pos_pred_q <= pos_pred_d;
        end
    end

    // ------------------------------------------------------------------------
    // Track generation
    // ------------------------------------------------------------------------
    always_comb begin
        if (speed_mode) begin
            target = 32'(accum_q >>> `EMU_SPEED_FRAC_BITS);
        end else begin
            target = pos_pred_q >>> shift_amt;
        end
    end

    quad_track_gen quad_track_gen_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(tracks_on),
        .target_i(target),
        .count_o(gen_count),
        .step_o(gen_step),
        .dir_up_o(gen_up),
        .track_a_o(gen_a),
        .track_b_o(gen_b)
    );

    // ------------------------------------------------------------------------
    // Zero mark
    // ------------------------------------------------------------------------
    logic [17:0] zero_pos_q, zero_pos_d, zero_wrap, zero_at;
    logic tracks_on_q, z_q, z_d;

    always_comb begin
        if (pos_mode && source_is_absolute_i) begin
            zero_wrap = edges_of(pulses_per_revolution_i);
            zero_at = edges_of(zero_mark_pulse_distance_i);
        end else begin
            zero_wrap = edges_of(zero_mark_pulse_distance_i);
            zero_at = 18'h00000;
        end
        zero_pos_d = zero_pos_q;
        if (tracks_on && !tracks_on_q) begin
            zero_pos_d = 18'h00000;
        end else if (gen_step && gen_up) begin
            zero_pos_d = (zero_pos_q + 18'h00001 >= zero_wrap) ? 18'h00000 :
                zero_pos_q + 18'h00001;
        end else if (gen_step) begin
            zero_pos_d = (zero_pos_q == 18'h00000) ? zero_wrap - 18'h00001 :
                zero_pos_q - 18'h00001;
        end
        z_d = zero_mark_enable_i && tracks_on && (zero_wrap != 18'h00000) &&
            (zero_pos_d == zero_at);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zero_pos_q <= 18'h00000;
            tracks_on_q <= 1'b0;
            z_q <= 1'b0;
        end else begin
            zero_pos_q <= zero_pos_d;
            tracks_on_q <= tracks_on;
            z_q <= z_d;
        end
    end

    // ------------------------------------------------------------------------
    // Status and differential outputs
    // ------------------------------------------------------------------------
    logic [15:0] status_d, status_q;
    logic [7:0] disp_d, disp_q;

    always_comb begin
        status_d = 16'h0000;
        status_d[`EMU_STAT_READY_BIT] = speed_mode && !fault;
        status_d[`EMU_STAT_RUNNING_BIT] = (seq_q == encoder_emulation_pkg::SEQ_RUN);
        status_d[`EMU_STAT_TRACKS_BIT] = tracks_on;
        status_d[`EMU_STAT_FAULT_BIT] = fault;
        if (fault) disp_d = `EMU_DISP_FAULT;
        else if (pos_mode) disp_d = `EMU_DISP_POSITION;
        else if (seq_q == encoder_emulation_pkg::SEQ_RUN) disp_d = `EMU_DISP_RUN;
        else if (seq_q == encoder_emulation_pkg::SEQ_STOPPING) disp_d = `EMU_DISP_STOPPING;
        else disp_d = `EMU_DISP_OFF;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_q <= 16'h0000;
            disp_q <= `EMU_DISP_OFF;
        end else begin
            status_q <= status_d;
            disp_q <= disp_d;
        end
    end

    always_comb begin
        sequence_control_word_o = 16'h0000;
        sequence_control_word_o[`EMU_CTRL_ON_BIT] = speed_mode && on_ramp_stop_command_command_i;
        sequence_control_word_o[`EMU_CTRL_RAMP_STOP_BIT] =
            (seq_q == encoder_emulation_pkg::SEQ_STOPPING);
    end

    assign sequence_status_word_o = status_q;
    assign operating_display_o = disp_q;
    assign tracks_enabled_flag_o = tracks_on_q;
    assign unsupported_source_o = status_q[`EMU_STAT_FAULT_BIT];
    assign track_a_p_o = gen_a;
    assign track_a_n_o = ~gen_a;
    assign track_b_p_o = gen_b;
    assign track_b_n_o = ~gen_b;
    assign track_z_p_o = z_q;
    assign track_z_n_o = ~z_q;

endmodule // encoder_emulation

`default_nettype wire

// ---- encoder_emulation_props.sv ----
// Port-level assertion checker for the encoder emulation.
`default_nettype none

module encoder_emulation_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic emulation_source_select_i,
    input wire logic zero_mark_enable_i,
    input wire logic source_is_resolver_i,
    input wire logic on_ramp_stop_command_command_i,
    input wire logic track_a_p_o,
    input wire logic track_a_n_o,
    input wire logic track_b_p_o,
    input wire logic track_b_n_o,
    input wire logic track_z_p_o,
    input wire logic track_z_n_o,
    input wire logic unsupported_source_o,
    input wire logic [15:0] sequence_control_word_o,
    input wire logic [15:0] sequence_status_word_o
);
    // ------------------------------------------------------------------------
    // Edge spacing helper and properties
    // ------------------------------------------------------------------------
    logic [1:0] ab_q, ab_d;
    logic [7:0] gap_q, gap_d;
    logic step;
    assign step = {track_a_p_o, track_b_p_o} != ab_q;
    always_comb begin
        ab_d = {track_a_p_o, track_b_p_o};
        gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
        if (step) begin
            gap_d = 8'h00;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ab_q <= 2'h0;
            gap_q <= 8'hff;
        end else begin
            ab_q <= ab_d;
            gap_q <= gap_d;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_diff;
        {track_a_n_o, track_b_n_o, track_z_n_o} == ~{track_a_p_o, track_b_p_o, track_z_p_o};
    endproperty
    property p_rate;
        step |-> gap_q >= 8'h18;
    endproperty
    property p_gray;
        !(track_a_p_o != ab_q[1] && track_b_p_o != ab_q[0]);
    endproperty
    property p_zoff;
        !zero_mark_enable_i [*3] |-> !track_z_p_o;
    endproperty
    property p_fault;
        emulation_source_select_i && source_is_resolver_i |=> unsupported_source_o;
    endproperty
    property p_fstat;
        unsupported_source_o == sequence_status_word_o[3];
    endproperty
    property p_ctrl;
        !emulation_source_select_i |-> sequence_control_word_o[0] == on_ramp_stop_command_command_i;
    endproperty
    property p_run;
        (!emulation_source_select_i && on_ramp_stop_command_command_i) [*3] |-> ##[0:2] sequence_status_word_o[1];
    endproperty
    a_diff: assert property (p_diff) else $error("track pair not complementary");
    a_rate: assert property (p_rate) else $error("track edges too close");
    a_gray: assert property (p_gray) else $error("both tracks moved at once");
    a_zoff: assert property (p_zoff) else $error("zero mark while disabled");
    a_fault: assert property (p_fault) else $error("resolver source not refused");
    a_fstat: assert property (p_fstat) else $error("fault flag and status differ");
    a_ctrl: assert property (p_ctrl) else $error("control word on bit wrong");
    a_run: assert property (p_run) else $error("sequence did not start");
    c_step: cover property (step);
    c_zero: cover property ($rose(track_z_p_o));
    c_fault: cover property (unsupported_source_o);
endmodule // encoder_emulation_props

bind encoder_emulation encoder_emulation_props encoder_emulation_props_i (
    .clk_i, .rst_n_i, .emulation_source_select_i, .zero_mark_enable_i, .source_is_resolver_i,
    .on_ramp_stop_command_command_i, .track_a_p_o, .track_a_n_o, .track_b_p_o, .track_b_n_o, .track_z_p_o,
    .track_z_n_o, .unsupported_source_o, .sequence_control_word_o, .sequence_status_word_o
);

`default_nettype wire

// ---- quad_counter_model.sv ----
// Quadrature counter standing in for the external position controller.
`default_nettype none

module quad_counter_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic a_i,
    input wire logic b_i,
    input wire logic z_i,
    output logic signed [31:0] count_o,
    output logic [7:0] z_seen_o,
    output logic signed [31:0] z_pos_o,
    output logic bad_step_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------------------
    logic [1:0] ab_q;
    logic z_q;
    logic [1:0] d;
    logic signed [31:0] nxt;
    function automatic logic [1:0] idx(input logic [1:0] ab);
        return {ab[0], ab[1] ^ ab[0]};
    endfunction
    assign d = idx({a_i, b_i}) - idx(ab_q);
    assign nxt = count_o + ((d == 2'h1) ? 32'sh1 : (d == 2'h3) ? -32'sh1 : 32'sh0);
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ab_q <= 2'h0;
            z_q <= 1'b0;
            count_o <= 32'sh0;
            z_seen_o <= 8'h00;
            z_pos_o <= 32'sh0;
            bad_step_o <= 1'b0;
        end else begin
            ab_q <= {a_i, b_i};
            z_q <= z_i;
            count_o <= nxt;
            if (d == 2'h2) begin
                bad_step_o <= 1'b1;
            end
            if (z_i && !z_q) begin
                z_seen_o <= z_seen_o + 8'h01;
                z_pos_o <= nxt;
            end
        end
    end
endmodule // quad_counter_model

`default_nettype wire

// ---- encoder_emulation_test.sv ----
// Self-checking bench for the encoder emulation.
`default_nettype none
`include "encoder_emulation_params.svh"

module encoder_emulation_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------------
    // Stimulus, model and checks
    // ------------------------------------------------------------------------
    logic clk_i, rst_n_i, sel, zen, inv, res, absl, pen, on, fen;
    logic a_p, a_n, b_p, b_n, z_p, z_n, flag, uns, bad;
    logic [15:0] ppr, zdist, per, ctrl, stat;
    logic [7:0] comp, disp, z_seen;
    logic [4:0] fine;
    logic [3:0] tc, damp, dly;
    logic signed [31:0] pos, spd, cnt, z_pos;
    int n_tests = 0;
    int fail_count = 0;
    encoder_emulation encoder_emulation_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .emulation_source_select_i(sel), .pulses_per_revolution_i(ppr),
        .zero_mark_enable_i(zen), .zero_mark_pulse_distance_i(zdist),
        .position_input_invert_i(inv), .deadtime_compensation_i(comp),
        .fine_resolution_bits_i(fine), .emulation_sample_period_i(per),
        .source_encoder_position_i(pos), .source_is_resolver_i(res),
        .source_is_absolute_i(absl), .position_enable_i(pen), .on_ramp_stop_command_command_i(on),
        .setpoint_filter_enable_i(fen), .filter_time_constant_i(tc), .filter_damping_i(damp),
        .setpoint_deadtime_i(dly), .speed_setpoint_input_i(spd), .track_a_p_o(a_p),
        .track_a_n_o(a_n), .track_b_p_o(b_p), .track_b_n_o(b_n), .track_z_p_o(z_p),
        .track_z_n_o(z_n), .tracks_enabled_flag_o(flag), .unsupported_source_o(uns),
        .sequence_control_word_o(ctrl), .sequence_status_word_o(stat),
        .operating_display_o(disp));
    quad_counter_model quad_counter_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .a_i(a_p),
        .b_i(b_p), .z_i(z_p), .count_o(cnt), .z_seen_o(z_seen), .z_pos_o(z_pos),
        .bad_step_o(bad));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic do_reset;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        cyc(20);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        cyc(5);
    endtask
    task automatic wait_pos(input logic [31:0] exp);
        for (int k = 0; k < 3000 && cnt !== exp; k++) cyc(1);
        check(cnt, exp);
    endtask
    initial begin
        rst_n_i = 1'b0;
        sel = 1'b0;
        ppr = 16'h0400;
        zen = 1'b1;
        zdist = 16'h0002;
        inv = 1'b0;
        comp = 8'h00;
        fine = 5'h02;
        per = 16'h0001;
        pos = 32'sh0;
        res = 1'b0;
        absl = 1'b0;
        pen = 1'b0;
        on = 1'b0;
        fen = 1'b1;
        tc = 4'h2;
        damp = 4'h2;
        dly = 4'h3;
        spd = 32'sh0;
        do_reset();
        check({a_p, a_n, b_p, b_n, z_p, z_n}, 32'h15);
        check(disp, `EMU_DISP_OFF);
        @(posedge clk_i);
        spd <= 32'sh80;
        on <= 1'b1;
        cyc(3);
        check(ctrl[0], 32'h1);
        cyc(3200);
        check(disp, `EMU_DISP_RUN);
        check({stat[2], flag}, 32'h3);
        check(bad, 32'h0);
        check({31'h0, cnt >= 32'sh60 && cnt <= 32'sh64}, 32'h1);
        check({z_seen, z_pos[23:0]}, 32'h0d_000060);
        @(posedge clk_i);
        on <= 1'b0;
        spd <= 32'sh0;
        cyc(3);
        check({ctrl[1], stat[0], disp}, {2'h3, `EMU_DISP_STOPPING});
        cyc(300);
        check({disp, stat[1], flag}, {`EMU_DISP_OFF, 2'h0});
        @(posedge clk_i);
        sel <= 1'b1;
        pen <= 1'b1;
        zen <= 1'b1;
        absl <= 1'b1;
        comp <= 8'h40;
        do_reset();
        @(posedge clk_i);
        pos <= 32'sh28;
        wait_pos(32'h28);
        check({z_seen, z_pos[23:0]}, 32'h01_000008);
        check(disp, `EMU_DISP_POSITION);
        @(posedge clk_i);
        inv <= 1'b1;
        fine <= 5'h04;
        zen <= 1'b0;
        absl <= 1'b0;
        pos <= 32'sh0;
        do_reset();
        @(posedge clk_i);
        pos <= 32'sha0;
        wait_pos(-32'sh28);
        check(z_seen, 32'h0);
        @(posedge clk_i);
        res <= 1'b1;
        pos <= 32'sh0;
        cyc(200);
        check({uns, flag, disp}, {2'h2, `EMU_DISP_FAULT});
        check(cnt, -32'sh28);
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        complete_run();
    end
endmodule // encoder_emulation_test

`default_nettype wire
